// >>> verilog/msd_pkg.sv
// msd_pkg: constants and types for the memory space decoder
// assumes one core clock; all users reference names as msd_pkg::name
// Behaviour
// - 8 KB on-chip program store when select high
// - select high, fetch at or below 1FFFH internal
// - select high, 2000H to FFFFH goes external
// - select low, every fetch goes external
// - 16-bit instruction address counter addresses program
// - program 00 to 6BH reserved for interrupt entries
// - lower RAM, upper RAM, register area separate
// - upper RAM and register area share addresses
// - four eight-register banks at 0 to 31
// - addresses 32 to 47 give 128 bits
// - stack anywhere in internal RAM, 256 max
// - 64 KB external data, 16 or 8-bit address
// - register area decoded at 128 to 255
// - status word bits 4,3 pick the active bank
package msd_pkg;
  localparam logic [15:0] INT_ROM_LAST  = 16'h1fff;  // last internal program address
  localparam logic [15:0] EXT_ROM_FIRST = 16'h2000;  // first external program address
  localparam logic [15:0] VEC_LAST      = 16'h006b;  // last interrupt entry location
  localparam logic [15:0] PC_RESET      = 16'h0000;  // counter after reset
  localparam logic [7:0]  HIGH_FIRST    = 8'h80;     // start of shared upper half
  localparam logic [7:0]  BANK_LAST     = 8'h1f;     // last working register byte
  localparam logic [7:0]  BIT_FIRST     = 8'h20;     // first bit-addressable byte
  localparam logic [7:0]  BIT_LAST      = 8'h2f;     // last bit-addressable byte
  localparam logic [7:0]  BYTE_ZERO     = 8'h00;     // reset value of data bytes
  localparam int          BANK_HI_POS   = 4;         // status word bank bit high
  localparam int          BANK_LO_POS   = 3;         // status word bank bit low

  // internal data access modes
  typedef enum logic [1:0] {
    MSD_DIRECT   = 2'h0,  // operand address in the instruction
    MSD_INDIRECT = 2'h1,  // address from a pointer register
    MSD_REGISTER = 2'h3,  // working register number 0..7
    MSD_BIT      = 2'h2   // bit address
  } msd_mode_t;

  // which physical block a data access reaches
  typedef enum logic [2:0] {
    MSD_T_NONE  = 3'h0,  // idle
    MSD_T_LOW   = 3'h1,  // lower 128 byte RAM
    MSD_T_UPPER = 3'h3,  // upper 128 byte RAM
    MSD_T_SFR   = 3'h2,  // peripheral register area
    MSD_T_EXT   = 3'h6   // external data space
  } msd_tgt_t;
endpackage

// >>> verilog/msd_fetch_route.sv
// msd_fetch_route: routes a program fetch address internal or external
// assumes the select level is already synchronised by the caller
`timescale 1ns/1ps
module msd_fetch_route (
  input  wire logic        sel_int_ok,  // synchronised access select, high allows internal
  input  wire logic [15:0] addr,        // fetch address
  output logic             to_internal, // fetch served from on-chip store
  output logic             is_vector    // address inside interrupt entry area
);
  // internal only when allowed and inside the 8 KB store
  always_comb begin
    to_internal = sel_int_ok && (addr <= msd_pkg::INT_ROM_LAST);
    is_vector   = (addr <= msd_pkg::VEC_LAST);
  end
endmodule

// >>> verilog/msd_decoder.sv
// msd_decoder: program fetch routing and internal/external data decoding
// assumes a core that issues one fetch and one data access per cycle
// assumes every request input comes from core logic on sys_clk
// only the select pin is asynchronous and passes the synchroniser
// internal data map: 00-1f banks, 20-2f bit bytes, 30-7f scratch
// 80-ff shared by upper RAM and the register area, split by mode
// every answer appears one edge after its request is sampled
// no storage here: strobes and addresses go to the memories
`timescale 1ns/1ps
module msd_decoder (
  input  wire logic                sys_clk,          // core clock
  input  wire logic                rst,              // synchronous reset, high
  input  wire logic                ext_access_select, // pin: high allows internal store
  input  wire logic                fetch_req,        // fetch next instruction
  input  wire logic                jump_req,         // load counter with jump target
  input  wire logic [15:0]         jump_addr,        // jump target
  input  wire logic [7:0]          status_word,      // core status word
  input  wire logic                data_req,         // internal data access
  input  wire logic                data_wr,          // access writes
  input  wire msd_pkg::msd_mode_t  data_mode,        // addressing mode
  input  wire logic [7:0]          data_addr,        // address, reg number or bit addr
  input  wire logic                xdata_req,        // external data access
  input  wire logic                xdata_wide,       // 16-bit address form
  input  wire logic [15:0]         xdata_ptr,        // 16-bit pointer
  input  wire logic [7:0]          xdata_lo,         // 8-bit pointer
  input  wire logic [7:0]          xdata_page,       // page byte for 8-bit form
  output logic [15:0]              instr_address_counter, // next instruction address
  output logic                     fetch_int,        // fetch goes to on-chip store
  output logic                     fetch_ext,        // fetch goes to external program
  output logic [15:0]              fetch_addr,       // address of issued fetch
  output logic                     fetch_vector,     // fetch in interrupt entry area
  output logic [7:0]               ram_addr,         // byte address into lower/upper RAM
  output logic                     ram_sel_low,      // strobe lower RAM
  output logic                     ram_sel_upper,    // strobe upper RAM
  output logic                     sfr_sel,          // strobe register area
  output logic [6:0]               sfr_offset,       // offset inside register area
  output logic                     bit_access,       // byte holds a single bit
  output logic [2:0]               bit_index,        // bit within addressed byte
  output logic                     acc_wr,           // registered write flag
  output msd_pkg::msd_tgt_t        acc_target,       // block reached
  output logic                     xdata_sel,        // external data strobe
  output logic [15:0]              xdata_addr        // external data address
);
  // three-stage synchroniser for the select pin
  logic sel_s1_ff;
  logic sel_s2_ff;
  logic sel_s3_ff;
  // accepted select level and its next value
  logic sel_ok_ff;
  logic nxt_sel_ok;

  // program side state
  logic [15:0] pc_ff;
  logic [15:0] nxt_pc;
  // fetch strobes, address and entry-area flag of the last fetch
  logic        fint_ff;
  logic        nxt_fint;
  logic        fext_ff;
  logic        nxt_fext;
  logic [15:0] faddr_ff;
  logic [15:0] nxt_faddr;
  logic        fvec_ff;
  logic        nxt_fvec;
  // route of the counter as it stands, from the routing module
  logic        route_int;  // combinational route of current counter
  logic        route_vec;  // current counter in entry area

  // data side state
  logic [7:0]        raddr_ff;
  logic [7:0]        nxt_raddr;
  logic              rlow_ff;
  logic              nxt_rlow;
  logic              rup_ff;
  logic              nxt_rup;
  logic              sfr_ff;
  logic              nxt_sfr;
  logic [6:0]        soff_ff;
  logic [6:0]        nxt_soff;
  logic              bacc_ff;
  logic              nxt_bacc;
  logic [2:0]        bidx_ff;
  logic [2:0]        nxt_bidx;
  // access kind and block reached
  logic              wr_ff;
  logic              nxt_wr;
  msd_pkg::msd_tgt_t tgt_ff;
  msd_pkg::msd_tgt_t nxt_tgt;
  // external data strobe and address
  logic              xsel_ff;
  logic              nxt_xsel;
  logic [15:0]       xaddr_ff;
  logic [15:0]       nxt_xaddr;

  // working register byte address from bank field and register number
  // bank bits sit at fixed status word positions
  function automatic logic [7:0] bank_addr(input logic [7:0] sw, input logic [2:0] rn);
    bank_addr = {3'h0, sw[msd_pkg::BANK_HI_POS], sw[msd_pkg::BANK_LO_POS], rn};
  endfunction

  // byte address in the shared upper half; used by the bit, direct and indirect modes
  function automatic logic upper_half(input logic [7:0] a);
    upper_half = (a >= msd_pkg::HIGH_FIRST);
  endfunction

  // fetch routing for the current counter value
  // the counter before its increment picks the route
  msd_fetch_route u_route (
    .sel_int_ok  (sel_ok_ff),
    .addr        (pc_ff),
    .to_internal (route_int),
    .is_vector   (route_vec)
  );

  // select pin accepted once the last two stages agree
  // a disagreement keeps the last accepted level, so a glitch is ignored
  always_comb begin
    nxt_sel_ok = (sel_s2_ff == sel_s3_ff) ? sel_s3_ff : sel_ok_ff;
  end

  // three stages in a row; reset means external program only
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      sel_s1_ff <= 1'b0;
      sel_s2_ff <= 1'b0;
      sel_s3_ff <= 1'b0;
      sel_ok_ff <= 1'b0;
    end else begin
      sel_s1_ff <= ext_access_select;
      sel_s2_ff <= sel_s1_ff;
      sel_s3_ff <= sel_s2_ff;
      sel_ok_ff <= nxt_sel_ok;
    end
  end

  // program counter and fetch strobes
  // counter wraps from ffff to 0000 on its own
  // strobes drop to zero unless a fetch is taken this cycle
  always_comb begin
    nxt_pc    = pc_ff;
    nxt_fint  = 1'b0;
    nxt_fext  = 1'b0;
    nxt_faddr = faddr_ff;
    nxt_fvec  = fvec_ff;
    // jump wins; no fetch strobe in the same cycle
    if (jump_req) begin
      nxt_pc = jump_addr;  // jump takes priority over fetch
    end else if (fetch_req) begin
      // a fetch is issued from the counter as it stands
      nxt_fint  = route_int;
      nxt_fext  = !route_int;
      nxt_faddr = pc_ff;
      nxt_fvec  = route_vec;
      nxt_pc    = pc_ff + 16'h0001;           // wraps at 64 KB
    end
  end

  // register the program side; counter restarts at the reset vector
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pc_ff    <= msd_pkg::PC_RESET;
      fint_ff  <= 1'b0;
      fext_ff  <= 1'b0;
      faddr_ff <= msd_pkg::PC_RESET;
      fvec_ff  <= 1'b0;
    end else begin
      pc_ff    <= nxt_pc;
      fint_ff  <= nxt_fint;
      fext_ff  <= nxt_fext;
      faddr_ff <= nxt_faddr;
      fvec_ff  <= nxt_fvec;
    end
  end

  // internal and external data decode
  // strobes and target last one cycle; addresses hold between accesses
  always_comb begin
    nxt_raddr = raddr_ff;
    nxt_rlow  = 1'b0;
    nxt_rup   = 1'b0;
    nxt_sfr   = 1'b0;
    nxt_soff  = soff_ff;
    nxt_bacc  = 1'b0;
    nxt_bidx  = bidx_ff;
    nxt_wr    = 1'b0;
    nxt_tgt   = msd_pkg::MSD_T_NONE;
    nxt_xsel  = 1'b0;
    nxt_xaddr = xaddr_ff;
    // internal access wins when both kinds are requested
    if (data_req) begin
      nxt_wr = data_wr;
      case (data_mode)
        // working register of the active bank
        msd_pkg::MSD_REGISTER: begin
          nxt_raddr = bank_addr(status_word, data_addr[2:0]);
          nxt_rlow  = 1'b1;
          nxt_tgt   = msd_pkg::MSD_T_LOW;
        end
        // single bit: low half in bit bytes, high half in the register area
        msd_pkg::MSD_BIT: begin
          nxt_bacc = 1'b1;
          nxt_bidx = data_addr[2:0];
          if (!upper_half(data_addr)) begin
            // bits 00..7F live in bytes 20H..2FH
            nxt_raddr = msd_pkg::BIT_FIRST + {4'h0, data_addr[6:3]};
            nxt_rlow  = 1'b1;
            nxt_tgt   = msd_pkg::MSD_T_LOW;
          end else begin
            // upper bits sit in register-area bytes at multiples of 8
            nxt_soff = {data_addr[6:3], 3'h0};
            nxt_sfr  = 1'b1;
            nxt_tgt  = msd_pkg::MSD_T_SFR;
          end
        end
        // direct: upper half is the register area
        msd_pkg::MSD_DIRECT: begin
          nxt_raddr = data_addr;
          if (upper_half(data_addr)) begin
            nxt_soff = data_addr[6:0];
            nxt_sfr  = 1'b1;
            nxt_tgt  = msd_pkg::MSD_T_SFR;
          end else begin
            nxt_rlow = 1'b1;
            nxt_tgt  = msd_pkg::MSD_T_LOW;
          end
        end
        msd_pkg::MSD_INDIRECT: begin
          // also the stack path: any byte of 256 RAM bytes
          nxt_raddr = data_addr;
          // pointer bytes from 80H up land in upper RAM
          if (upper_half(data_addr)) begin
            nxt_rup = 1'b1;
            nxt_tgt = msd_pkg::MSD_T_UPPER;
          end else begin
            nxt_rlow = 1'b1;
            nxt_tgt  = msd_pkg::MSD_T_LOW;
          end
        end
        // unknown mode reaches nothing
        default: begin
          nxt_tgt = msd_pkg::MSD_T_NONE;
        end
      endcase
    end else if (xdata_req) begin
      // external data: full pointer or page byte with low byte
      nxt_xsel  = 1'b1;
      nxt_wr    = data_wr;
      nxt_tgt   = msd_pkg::MSD_T_EXT;
      nxt_xaddr = xdata_wide ? xdata_ptr : {xdata_page, xdata_lo};
    end
  end

  // register the data side; nothing is selected during reset
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      raddr_ff <= msd_pkg::BYTE_ZERO;
      rlow_ff  <= 1'b0;
      rup_ff   <= 1'b0;
      sfr_ff   <= 1'b0;
      soff_ff  <= 7'h00;
      bacc_ff  <= 1'b0;
      bidx_ff  <= 3'h0;
      wr_ff    <= 1'b0;
      tgt_ff   <= msd_pkg::MSD_T_NONE;
      xsel_ff  <= 1'b0;
      xaddr_ff <= 16'h0000;
    end else begin
      raddr_ff <= nxt_raddr;
      rlow_ff  <= nxt_rlow;
      rup_ff   <= nxt_rup;
      sfr_ff   <= nxt_sfr;
      soff_ff  <= nxt_soff;
      bacc_ff  <= nxt_bacc;
      bidx_ff  <= nxt_bidx;
      wr_ff    <= nxt_wr;
      tgt_ff   <= nxt_tgt;
      xsel_ff  <= nxt_xsel;
      xaddr_ff <= nxt_xaddr;
    end
  end

  // outputs straight from flip-flops
  // program side
  assign instr_address_counter = pc_ff;
  assign fetch_int     = fint_ff;
  assign fetch_ext     = fext_ff;
  assign fetch_addr    = faddr_ff;
  assign fetch_vector  = fvec_ff;

  // internal data side
  assign ram_addr      = raddr_ff;
  assign ram_sel_low   = rlow_ff;
  assign ram_sel_upper = rup_ff;
  assign sfr_sel       = sfr_ff;
  assign sfr_offset    = soff_ff;
  assign bit_access    = bacc_ff;
  assign bit_index     = bidx_ff;
  assign acc_wr        = wr_ff;
  assign acc_target    = tgt_ff;

  // external data side
  assign xdata_sel     = xsel_ff;
  assign xdata_addr    = xaddr_ff;
endmodule

// >>> sim/msd_decoder_asserts.sv
// checker for the memory space decoder, watching top ports only
// assumes sys_clk domain, synchronous active-high rst
`timescale 1ns/1ps
module msd_chk (
  input wire logic               sys_clk,               // core clock
  input wire logic               rst,                   // sync reset
  input wire logic               ext_access_select,     // select pin
  input wire logic               fetch_req,             // fetch request
  input wire logic               jump_req,              // jump request
  input wire logic [7:0]         status_word,           // bank bits
  input wire logic               data_req,              // data access
  input wire msd_pkg::msd_mode_t data_mode,             // access mode
  input wire logic [7:0]         data_addr,             // data address
  input wire logic               xdata_req,             // xdata access
  input wire logic               xdata_wide,            // 16-bit form
  input wire logic [15:0]        xdata_ptr,             // wide pointer
  input wire logic [7:0]         xdata_lo,              // low byte
  input wire logic [7:0]         xdata_page,            // page byte
  input wire logic [15:0]        instr_address_counter, // counter
  input wire logic               fetch_int,             // internal strobe
  input wire logic               fetch_ext,             // external strobe
  input wire logic [15:0]        fetch_addr,            // fetch address
  input wire logic               fetch_vector,          // vector flag
  input wire logic [7:0]         ram_addr,              // ram byte
  input wire logic               ram_sel_low,           // lower ram
  input wire logic               ram_sel_upper,         // upper ram
  input wire logic               sfr_sel,               // register area
  input wire logic [6:0]         sfr_offset,            // area offset
  input wire msd_pkg::msd_tgt_t  acc_target,            // target code
  input wire logic               xdata_sel,             // xdata strobe
  input wire logic [15:0]        xdata_addr             // xdata address
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  a_fetch_one_route: assert property (fetch_req && !jump_req |=> fetch_int ^ fetch_ext)
    else $error("fetch strobe count wrong");
  a_low_sel_ext: assert property (
    (!ext_access_select)[*6] ##0 (fetch_req && !jump_req) |=> fetch_ext)
    else $error("low select fetch not external");
  a_high_sel_int: assert property (
    ext_access_select[*6] ##0 (fetch_req && !jump_req && instr_address_counter <= 16'h1fff)
    |=> fetch_int) else $error("low fetch not internal");
  a_high_sel_ext: assert property (
    ext_access_select[*6] ##0 (fetch_req && !jump_req && instr_address_counter >= 16'h2000)
    |=> fetch_ext) else $error("high fetch not external");
  a_pc_step_addr: assert property (
    fetch_req && !jump_req |=> fetch_addr == $past(instr_address_counter)
    && instr_address_counter == $past(instr_address_counter) + 16'h1)
    else $error("counter step wrong");
  a_vector_area: assert property (
    fetch_int || fetch_ext |-> fetch_vector == (fetch_addr <= 16'h006b))
    else $error("vector flag wrong");
  a_direct_high_sfr: assert property (
    data_req && data_mode == msd_pkg::MSD_DIRECT && data_addr[7]
    |=> sfr_sel && !ram_sel_upper && sfr_offset == $past(data_addr[6:0])
    && acc_target == msd_pkg::MSD_T_SFR) else $error("direct high not register area");
  a_indirect_upper: assert property (
    data_req && data_mode == msd_pkg::MSD_INDIRECT && data_addr[7]
    |=> ram_sel_upper && !sfr_sel && ram_addr == $past(data_addr))
    else $error("indirect high wrong");
  a_bank_select: assert property (
    data_req && data_mode == msd_pkg::MSD_REGISTER |=> ram_sel_low
    && ram_addr == {3'h0, $past(status_word[4:3]), $past(data_addr[2:0])})
    else $error("bank wrong");
  a_xdata_form: assert property (
    xdata_req && !data_req |=> xdata_sel && xdata_addr == ($past(xdata_wide)
    ? $past(xdata_ptr) : {$past(xdata_page), $past(xdata_lo)}))
    else $error("xdata address wrong");
endmodule
bind msd_decoder msd_chk i_msd_chk (.sys_clk(sys_clk), .rst(rst),
  .ext_access_select(ext_access_select), .fetch_req(fetch_req), .jump_req(jump_req),
  .status_word(status_word), .data_req(data_req), .data_mode(data_mode), .data_addr(data_addr),
  .xdata_req(xdata_req), .xdata_wide(xdata_wide), .xdata_ptr(xdata_ptr), .xdata_lo(xdata_lo),
  .xdata_page(xdata_page), .instr_address_counter(instr_address_counter),
  .fetch_int(fetch_int), .fetch_ext(fetch_ext), .fetch_addr(fetch_addr),
  .fetch_vector(fetch_vector), .ram_addr(ram_addr), .ram_sel_low(ram_sel_low),
  .ram_sel_upper(ram_sel_upper), .sfr_sel(sfr_sel), .sfr_offset(sfr_offset),
  .acc_target(acc_target), .xdata_sel(xdata_sel), .xdata_addr(xdata_addr));

// >>> sim/msd_ext_mem.sv
// external program and data memory model: counts accesses it serves
// assumes strobes are one-cycle pulses on sys_clk
`timescale 1ns/1ps
module msd_ext_mem (
  input  wire logic sys_clk,  // core clock
  input  wire logic rst,      // sync reset
  input  wire logic fetch_ext, // program read strobe
  input  wire logic xdata_sel, // data strobe
  output logic [7:0] n_fetch, // program reads served
  output logic [7:0] n_xdata  // data accesses served
);
  // every strobe counted on both memories; no address input on either
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      n_fetch <= 8'h00;
      n_xdata <= 8'h00;
    end else begin
      n_fetch <= n_fetch + {7'h00, fetch_ext};
      n_xdata <= n_xdata + {7'h00, xdata_sel};
    end
  end
endmodule

// >>> sim/mcu_memory_space_decoder_tb_top.sv
// testbench for the memory space decoder with an external memory model
// assumes 250 MHz sys_clk and registered one-cycle answers
`timescale 1ns/1ps
module mcu_memory_space_decoder_tb_top;
  logic sys_clk, rst, ext_access_select, fetch_req, jump_req, data_req, data_wr; // drives
  logic xdata_req, xdata_wide;                  // xdata drives
  logic [15:0] jump_addr, xdata_ptr;            // wide inputs
  logic [7:0]  status_word, data_addr, xdata_lo, xdata_page; // byte inputs
  msd_pkg::msd_mode_t data_mode;                // access mode
  logic [15:0] pc, fa, xa;                      // counter, fetch and xdata address
  logic fi, fe, fv, rl, ru, ss, ba, aw, xs;     // strobes and flags
  logic [7:0]  ra, n_fetch, n_xdata;            // ram address, model counts
  logic [6:0]  so;                              // register area offset
  logic [2:0]  bi;                              // bit index
  msd_pkg::msd_tgt_t at;                        // target
  int mismatches, total_checks;                 // scoreboard
  msd_decoder i_msd_decoder (.sys_clk(sys_clk), .rst(rst), .ext_access_select(ext_access_select),
    .fetch_req(fetch_req), .jump_req(jump_req), .jump_addr(jump_addr), .status_word(status_word),
    .data_req(data_req), .data_wr(data_wr), .data_mode(data_mode), .data_addr(data_addr),
    .xdata_req(xdata_req), .xdata_wide(xdata_wide), .xdata_ptr(xdata_ptr), .xdata_lo(xdata_lo),
    .xdata_page(xdata_page), .instr_address_counter(pc), .fetch_int(fi), .fetch_ext(fe),
    .fetch_addr(fa), .fetch_vector(fv), .ram_addr(ra), .ram_sel_low(rl), .ram_sel_upper(ru),
    .sfr_sel(ss), .sfr_offset(so), .bit_access(ba), .bit_index(bi), .acc_wr(aw),
    .acc_target(at), .xdata_sel(xs), .xdata_addr(xa));
  msd_ext_mem i_msd_ext_mem (.sys_clk(sys_clk), .rst(rst), .fetch_ext(fe), .xdata_sel(xs),
    .n_fetch(n_fetch), .n_xdata(n_xdata));
  // compare and count
  task chk(input string n, input logic [15:0] e, input logic [15:0] g);
    total_checks++;
    if (g !== e) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  task conclude;
    if (mismatches == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // one-cycle request pulses, sampled after the answering edge
  task jmp(input logic [15:0] a);
    @(posedge sys_clk) begin jump_req <= 1'b1; jump_addr <= a; end
    @(posedge sys_clk) jump_req <= 1'b0;
    #1 chk("counter", a, pc);
  endtask
  task fet;
    @(posedge sys_clk) fetch_req <= 1'b1;
    @(posedge sys_clk) fetch_req <= 1'b0;
    #1;
  endtask
  task dacc(input msd_pkg::msd_mode_t m, input logic [7:0] a, input logic w);
    @(posedge sys_clk) begin data_req <= 1'b1; data_mode <= m; data_addr <= a; data_wr <= w; end
    @(posedge sys_clk) data_req <= 1'b0;
    #1;
  endtask
  task xacc(input logic w);
    @(posedge sys_clk) begin xdata_req <= 1'b1; xdata_wide <= w; end
    @(posedge sys_clk) xdata_req <= 1'b0;
    #1;
  endtask
  // select low: all external, vector edge at 6bh
  task t_low;
    jmp(16'h006b); fet; chk("ext", 1, fe); chk("int", 0, fi); chk("vec", 1, fv);
    jmp(16'h006c); fet; chk("vec", 0, fv); chk("ext", 1, fe);
  endtask
  // select high: back-to-back fetches across 1fff/2000
  task t_boundary;
    @(posedge sys_clk) ext_access_select <= 1'b1;
    repeat (6) @(posedge sys_clk);
    jmp(16'h1ffe);
    @(posedge sys_clk) fetch_req <= 1'b1;
    for (int i = 0; i < 3; i++) begin
      @(posedge sys_clk) if (i == 2) fetch_req <= 1'b0;
      #1 chk("int", {15'h0, i < 2}, fi);
      chk("ext", {15'h0, i == 2}, fe);
      chk("faddr", 16'h1ffe + 16'(i), fa);
    end
    chk("counter", 16'h2001, pc);
    jmp(16'hffff); fet; chk("ext", 1, fe); chk("counter", 16'h0000, pc);
    @(posedge sys_clk) begin jump_req <= 1'b1; fetch_req <= 1'b1; jump_addr <= 16'h0100; end
    @(posedge sys_clk) begin jump_req <= 1'b0; fetch_req <= 1'b0; end
    #1 chk("nofetch", 0, {fi, fe}); chk("counter", 16'h0100, pc);
    fet; chk("int", 1, fi);
  endtask
  // banks, modes in the shared upper half, bits
  task t_data;
    for (int b = 0; b < 4; b++) begin
      @(posedge sys_clk) status_word <= {3'h0, 2'(b), 3'h0};
      dacc(msd_pkg::MSD_REGISTER, 8'h05, 1'b0);
      chk("bank", 16'(b * 8 + 5), {8'h0, ra}); chk("low", 1, rl);
    end
    dacc(msd_pkg::MSD_DIRECT, 8'h90, 1'b1);
    chk("sfr", 1, ss); chk("off", 16'h10, {9'h0, so}); chk("wr", 1, aw);
    chk("tgt", 16'h2, {13'h0, at});
    dacc(msd_pkg::MSD_INDIRECT, 8'h90, 1'b0);
    chk("upper", 1, ru); chk("sfr", 0, ss); chk("ram", 16'h90, {8'h0, ra});
    dacc(msd_pkg::MSD_DIRECT, 8'h30, 1'b0);
    chk("low", 1, rl); chk("ram", 16'h30, {8'h0, ra});
    dacc(msd_pkg::MSD_BIT, 8'h7f, 1'b0);
    chk("bit", 1, ba); chk("ram", 16'h2f, {8'h0, ra}); chk("idx", 7, {13'h0, bi});
    dacc(msd_pkg::MSD_BIT, 8'h88, 1'b0);
    chk("sfr", 1, ss); chk("off", 16'h08, {9'h0, so});
  endtask
  // both external data address forms
  task t_xdata;
    xacc(1'b1); chk("xsel", 1, xs); chk("xaddr", 16'hc3a5, xa);
    xacc(1'b0); chk("xaddr", 16'h1234, xa); chk("tgt", 16'h6, {13'h0, at});
    @(posedge sys_clk);  // model counts the last strobe at this edge
    #1;
    chk("model fetch", 16'h4, {8'h0, n_fetch});
    chk("model xdata", 16'h2, {8'h0, n_xdata});
  endtask
  // clock
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  // main sequence
  initial begin
    rst = 1'b1; ext_access_select = 1'b0; fetch_req = 1'b0; jump_req = 1'b0; data_req = 1'b0;
    data_wr = 1'b0; xdata_req = 1'b0; xdata_wide = 1'b0; jump_addr = 16'h0; status_word = 8'h0;
    data_mode = msd_pkg::MSD_DIRECT; data_addr = 8'h0; xdata_ptr = 16'hc3a5; xdata_lo = 8'h34;
    xdata_page = 8'h12; mismatches = 0; total_checks = 0;
    repeat (6) @(posedge sys_clk);
    rst <= 1'b0;
    t_low; t_boundary; t_data; t_xdata;
    conclude;
  end
  // watchdog against a hang
  initial begin
    repeat (5000) @(posedge sys_clk);
    mismatches++;
    conclude;
  end
endmodule
